// [verilog/rtcs_ctrl.sv]
// RTC second, minute and alarm events with temperature measurement scheduling over APB
`timescale 1ns/1ps
`include "rtcs_defs.svh"
module rtcs_ctrl import rtcs_pkg::*; #(
  parameter int unsigned SEC_CYCLES = `RTCS_SEC_CYCLES,
  parameter int unsigned COMMIT_CYCLES = `RTCS_COMMIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Power state
  input wire rtcs_pwr_mode_type power_mode_in,
  input wire logic wake_in,
  // Temperature sensor
  output logic sensor_enable_out,
  input wire logic sensor_ready_in,
  input wire logic [10:0] sensor_code_in,
  output logic sensor_supply_main_out,
  output logic battery_select_main_out,
  // Events
  output logic second_tick_event_out,
  output logic minute_tick_event_out,
  output logic alarm_event_out,
  output logic ext_int6_out
);
  rtcs_meas_if mi ();

  logic [24:0] presc_r;
  logic sec_tick;
  logic [5:0] sec_r;
  logic [5:0] min_r;
  logic [4:0] hr_r;
  logic [5:0] min_nxt;
  logic [4:0] hr_nxt;
  logic min_wrap;
  logic alarm_nxt;
  logic [5:0] alm_min_r;
  logic [4:0] alm_hr_r;
  logic sec_ev_r;
  logic min_ev_r;
  logic alm_ev_r;
  logic int6_r;
  logic [2:0] period_r;
  logic pwr_sel_r;
  logic bsel_r;
  logic busy_r;
  logic [17:0] commit_cnt_r;
  logic [7:0] pend_r;
  logic commit_done;
  logic start_r;
  logic auto_pend_r;
  logic [8:0] per_sec_r;
  logic [8:0] per_mask;
  logic auto_trig;
  logic mode_active;
  logic supply_r;
  logic [13:0] idx;
  logic acc;
  logic wr;
  logic hit;
  logic [31:0] rd_data;
  logic [31:0] prdata_r;

  // ==========================================================
  // Timekeeping
  assign sec_tick = (presc_r == 25'(SEC_CYCLES - 1));
  assign min_wrap = sec_tick && (sec_r == `RTCS_SEC_LAST);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc_r <= 25'h0000000;
    end else if (sec_tick) begin
      presc_r <= 25'h0000000;
    end else begin
      presc_r <= presc_r + 25'h0000001;
    end
  end

  always_comb begin
    min_nxt = min_r;
    hr_nxt = hr_r;
    if (min_wrap) begin
      min_nxt = (min_r == `RTCS_MIN_LAST) ? 6'h00 : min_r + 6'h01;
      if (min_r == `RTCS_MIN_LAST) begin
        hr_nxt = (hr_r == `RTCS_HR_LAST) ? 5'h00 : hr_r + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sec_r <= 6'h00;
      min_r <= 6'h00;
      hr_r <= 5'h00;
    end else if (sec_tick) begin
      sec_r <= (sec_r == `RTCS_SEC_LAST) ? 6'h00 : sec_r + 6'h01;
      min_r <= min_nxt;
      hr_r <= hr_nxt;
    end
  end

  // ==========================================================
  // Events
  // Alarm only fires when the time moves onto the target, not when software writes it
  assign alarm_nxt = min_wrap && (min_nxt == alm_min_r) && (hr_nxt == alm_hr_r);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sec_ev_r <= 1'b0;
      min_ev_r <= 1'b0;
      alm_ev_r <= 1'b0;
      int6_r <= 1'b0;
    end else begin
      sec_ev_r <= sec_tick;
      min_ev_r <= min_wrap;
      alm_ev_r <= alarm_nxt;
      int6_r <= sec_tick | min_wrap | alarm_nxt;
    end
  end

  assign second_tick_event_out = sec_ev_r;
  assign minute_tick_event_out = min_ev_r;
  assign alarm_event_out = alm_ev_r;
  assign ext_int6_out = int6_r;

  // ==========================================================
  // APB decode
  assign idx = paddr_in[15:2];
  assign acc = psel_in && penable_in;
  assign wr = acc && pwrite_in;

  always_comb begin
    hit = 1'b1;
    rd_data = 32'h00000000;
    case (idx)
      `RTCS_IDX_RES_HI: rd_data[7:0] = mi.result[10:3];
      `RTCS_IDX_RES_LO: rd_data[7:5] = mi.result[2:0];
      `RTCS_IDX_ALM_MIN: rd_data[5:0] = alm_min_r;
      `RTCS_IDX_ALM_HR: rd_data[4:0] = alm_hr_r;
      `RTCS_IDX_CFG: begin
        rd_data[`RTCS_CFG_BSEL] = bsel_r;
        rd_data[`RTCS_CFG_PWR] = pwr_sel_r;
        rd_data[`RTCS_CFG_BUSY] = busy_r;
        rd_data[2:0] = period_r;
      end
      `RTCS_IDX_START: rd_data[`RTCS_START_BIT] = start_r;
      `RTCS_IDX_TIME: rd_data = {11'h000, hr_r, 2'h0, min_r, 2'h0, sec_r};
      default: hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup phase so it comes from a flip-flop
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_r <= 32'h00000000;
    end else if (psel_in && !penable_in) begin
      prdata_r <= rd_data;
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = 1'b1;
  assign pslverr_out = acc && !hit;

  // ==========================================================
  // Alarm targets
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      alm_min_r <= `RTCS_ALM_MIN_RST;
      alm_hr_r <= `RTCS_ALM_HR_RST;
    end else if (wake_in) begin
      alm_min_r <= `RTCS_ALM_MIN_RST;
      alm_hr_r <= `RTCS_ALM_HR_RST;
    end else if (wr && idx == `RTCS_IDX_ALM_MIN) begin
      alm_min_r <= pwdata_in[5:0];
    end else if (wr && idx == `RTCS_IDX_ALM_HR) begin
      alm_hr_r <= pwdata_in[4:0];
    end
  end

  // ==========================================================
  // Configuration byte commit
  assign commit_done = busy_r && (commit_cnt_r == 18'(COMMIT_CYCLES - 1));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_r <= 1'b0;
      commit_cnt_r <= 18'h00000;
      pend_r <= 8'h00;
    end else if (busy_r) begin
      // Writes landing here are dropped; software polls busy first
      commit_cnt_r <= commit_cnt_r + 18'h00001;
      busy_r <= !commit_done;
    end else if (wr && idx == `RTCS_IDX_CFG) begin
      busy_r <= 1'b1;
      commit_cnt_r <= 18'h00000;
      pend_r <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      period_r <= `RTCS_PER_RST;
      pwr_sel_r <= 1'b0;
      bsel_r <= 1'b0;
    end else if (commit_done) begin
      period_r <= pend_r[2:0];
      pwr_sel_r <= pend_r[`RTCS_CFG_PWR];
      bsel_r <= pend_r[`RTCS_CFG_BSEL];
    end
  end

  // ==========================================================
  // Sensor supply and battery selection
  assign mode_active = (power_mode_in == PM_MISSION) || (power_mode_in == PM_BROWNOUT);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      supply_r <= 1'b0;
    end else begin
      supply_r <= pwr_sel_r && mode_active;
    end
  end

  assign sensor_supply_main_out = supply_r;
  assign battery_select_main_out = bsel_r;

  // ==========================================================
  // Measurement scheduling
  assign per_mask = ~(9'h1FF << (`RTCS_PER_BASE + {1'b0, period_r}));
  assign auto_trig = (period_r == `RTCS_PER_CONT) ||
    ((period_r != `RTCS_PER_MANUAL) && sec_tick && ((per_sec_r & per_mask) == per_mask));

  // Interval phase restarts on every committed period change
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      per_sec_r <= 9'h000;
    end else if (commit_done) begin
      per_sec_r <= 9'h000;
    end else if (sec_tick) begin
      per_sec_r <= per_sec_r + 9'h001;
    end
  end

  // Power mode plays no part here, so periodic runs go on in every mode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      auto_pend_r <= 1'b0;
    end else if (auto_trig) begin
      auto_pend_r <= 1'b1;
    end else if (mi.start && !mi.busy) begin
      auto_pend_r <= 1'b0;
    end
  end

  // Start stays high until its run completes; a new start in that cycle wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_r <= 1'b0;
    end else if (wr && idx == `RTCS_IDX_START && pwdata_in[`RTCS_START_BIT] &&
                 period_r == `RTCS_PER_MANUAL && mode_active) begin
      start_r <= 1'b1;
    end else if (mi.done) begin
      start_r <= 1'b0;
    end
  end

  assign mi.start = start_r || auto_pend_r;

  // Dedicated engine, independent of the main converter
  rtcs_temp_meas u_meas (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .mi(mi),
    .sensor_enable_out(sensor_enable_out),
    .sensor_ready_in(sensor_ready_in),
    .sensor_code_in(sensor_code_in)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_minute_on_second: assert property (min_ev_r |-> sec_ev_r && sec_r == 6'h00)
    else $error("minute tick without second tick at second zero");
  a_alarm_match: assert property (alm_ev_r |-> min_r == alm_min_r && hr_r == alm_hr_r)
    else $error("alarm raised without target match");
  a_shared_irq: assert property ((sec_ev_r || min_ev_r || alm_ev_r) |-> ext_int6_out)
    else $error("event missing on interrupt six");
  a_wake_clear: assert property (wake_in |=> alm_min_r == 6'h00 && alm_hr_r == 5'h00)
    else $error("alarm targets not cleared by wake");
  a_start_ignored: assert property (
    (wr && idx == `RTCS_IDX_START && !start_r && (!mode_active || period_r != 3'h0))
    |=> !start_r)
    else $error("start accepted when it must be ignored");
  a_manual_run: assert property ((start_r && !mi.busy) |=> mi.busy)
    else $error("manual start did not launch a measurement");
  a_cont_restart: assert property ((period_r == 3'h7 && mi.done) |-> ##[1:2] mi.busy)
    else $error("continuous mode did not restart");
  a_busy_lock: assert property ((busy_r && wr && idx == `RTCS_IDX_CFG) |=> $stable(pend_r))
    else $error("config write accepted while busy");
  a_commit_apply: assert property (commit_done |=> !busy_r && period_r == $past(pend_r[2:0]))
    else $error("commit did not apply pending config");
  a_low_mode_supply: assert property (!mode_active |=> !sensor_supply_main_out)
    else $error("main supply used in sleep or display-only mode");

  c_alarm: cover property (alm_ev_r);
  c_manual: cover property (start_r && mi.done);
  c_periodic: cover property (period_r == 3'h1 && auto_trig);
  c_commit: cover property (commit_done);
endmodule

// [common/rtcs_defs.svh]
// Offsets, field positions, reset values and timing counts of the RTC event and temp block
`ifndef RTCS_DEFS_SVH
`define RTCS_DEFS_SVH

// ==========================================================
// Timing
`define RTCS_CLK_NS 40
`define RTCS_SEC_NS 1000000000
`define RTCS_SEC_CYCLES (`RTCS_SEC_NS / `RTCS_CLK_NS)
`define RTCS_COMMIT_NS 6000000
`define RTCS_COMMIT_CYCLES (`RTCS_COMMIT_NS / `RTCS_CLK_NS)

// ==========================================================
// Register indices (byte address is four times the index)
`define RTCS_IDX_RES_HI 14'h2881
`define RTCS_IDX_RES_LO 14'h2882
`define RTCS_IDX_ALM_MIN 14'h289E
`define RTCS_IDX_ALM_HR 14'h289F
`define RTCS_IDX_CFG 14'h28A0
`define RTCS_IDX_START 14'h28B4
`define RTCS_IDX_TIME 14'h28C0

// ==========================================================
// Field positions
`define RTCS_CFG_BSEL 7
`define RTCS_CFG_PWR 6
`define RTCS_CFG_BUSY 3
`define RTCS_START_BIT 6

// ==========================================================
// Reset values and limits
`define RTCS_ALM_MIN_RST 6'h00
`define RTCS_ALM_HR_RST 5'h00
`define RTCS_PER_RST 3'h0
`define RTCS_SEC_LAST 6'h3B
`define RTCS_MIN_LAST 6'h3B
`define RTCS_HR_LAST 5'h17
`define RTCS_PER_MANUAL 3'h0
`define RTCS_PER_CONT 3'h7
`define RTCS_PER_BASE 4'h3

`endif

// [common/rtcs_pkg.sv]
// Types shared by the RTC event and temperature measurement block
package rtcs_pkg;
  typedef enum logic [1:0] {
    PM_MISSION = 2'h0,
    PM_BROWNOUT = 2'h1,
    PM_DISPLAY_ONLY = 2'h2,
    PM_SLEEP = 2'h3
  } rtcs_pwr_mode_type;

  typedef enum logic [1:0] {
    MS_IDLE = 2'h1,
    MS_RUN = 2'h2
  } rtcs_meas_state_type;
endpackage

// [common/rtcs_meas_if.sv]
// Handshake between the scheduler and the temperature measurement engine
`timescale 1ns/1ps
interface rtcs_meas_if;
  logic start;
  logic busy;
  logic done;
  logic [10:0] result;
  modport ctrl (output start, input busy, input done, input result);
  modport eng (input start, output busy, output done, output result);
endinterface

// [verilog/rtcs_temp_meas.sv]
// Temperature measurement engine driving the sensor wake and capturing its code
`timescale 1ns/1ps
module rtcs_temp_meas import rtcs_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Scheduler side
  rtcs_meas_if.eng mi,
  // Sensor
  output logic sensor_enable_out,
  input wire logic sensor_ready_in,
  input wire logic [10:0] sensor_code_in
);
  rtcs_meas_state_type state_r;
  logic [10:0] result_r;

  // ==========================================================
  // Sequencer
  // A starved battery just keeps the run open; a supply switch by software lets it finish
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= MS_IDLE;
    end else begin
      case (state_r)
        MS_IDLE: begin
          if (mi.start) begin
            state_r <= MS_RUN;
          end
        end
        MS_RUN: begin
          if (sensor_ready_in) begin
            state_r <= MS_IDLE;
          end
        end
        default: state_r <= MS_IDLE;
      endcase
    end
  end

  // One register holds all eleven bits, so both bytes always change together
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_r <= 11'h000;
    end else if (state_r == MS_RUN && sensor_ready_in) begin
      result_r <= sensor_code_in;
    end
  end

  assign sensor_enable_out = (state_r == MS_RUN);
  assign mi.busy = (state_r == MS_RUN);
  assign mi.done = (state_r == MS_RUN) && sensor_ready_in;
  assign mi.result = result_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_result_capture: assert property (mi.done |=> mi.result == $past(sensor_code_in))
    else $error("result not taken from sensor at completion");
  a_result_steady: assert property (!mi.done |=> $stable(mi.result))
    else $error("result changed without a completion");
endmodule

// [verification/rtcs_sensor_model.sv]
// Behavioural temperature sensor that answers each wake after a fixed delay
`timescale 1ns/1ps
module rtcs_sensor_model #(
  parameter int DELAY = 3
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Sensor pins
  input wire logic enable_in,
  input wire logic [10:0] code_in,
  output logic ready_out,
  output logic [10:0] code_out
);
  int cnt;
  // ==========================================================
  // Conversion
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 0;
      ready_out <= 1'b0;
      code_out <= 11'h000;
    end else begin
      ready_out <= 1'b0;
      // Outside the ready cycle the code toggles so a stale value never matches
      code_out <= ~code_out;
      cnt <= 0;
      if (enable_in && !ready_out) begin
        if (cnt == DELAY) begin
          ready_out <= 1'b1;
          code_out <= code_in;
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule

// [verification/rtcs_ctrl_tb.sv]
// Self-checking bench for the RTC event and temperature scheduling block
`timescale 1ns/1ps
`include "rtcs_defs.svh"
module rtcs_ctrl_tb import rtcs_pkg::*;;
  // Short second and commit so a whole minute fits in a short run
  localparam int SEC = 20;
  localparam int COMMIT = 8;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  rtcs_pwr_mode_type mode = PM_MISSION;
  logic wake = 1'b0;
  logic [10:0] code = 11'h000;
  logic [31:0] prdata;
  logic pready, pslverr, sen, srdy, supply, bsel, sec_ev, min_ev, alm_ev, int6;
  logic [10:0] scode;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  rtcs_ctrl #(.SEC_CYCLES(SEC), .COMMIT_CYCLES(COMMIT)) DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .power_mode_in(mode), .wake_in(wake),
    .sensor_enable_out(sen), .sensor_ready_in(srdy), .sensor_code_in(scode),
    .sensor_supply_main_out(supply), .battery_select_main_out(bsel),
    .second_tick_event_out(sec_ev), .minute_tick_event_out(min_ev),
    .alarm_event_out(alm_ev), .ext_int6_out(int6));

  rtcs_sensor_model SENSOR (.clk_in(clk_in), .rst_n_in(rst_n_in), .enable_in(sen),
    .code_in(code), .ready_out(srdy), .code_out(scode));

  // ==========================================================
  // Clock, timeout and shared tasks
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 10000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Waits for pready with no limit of its own; only the cycle ceiling ends a hang
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, idx, d, q, e);
  endtask

  task automatic rd(input logic [13:0] idx, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    logic e;
    apb(1'b0, idx, 32'h0, q, e);
    chk(nm, exp, q);
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return sen;
      1: return ~sen;
      2: return min_ev;
      default: return alm_ev;
    endcase
  endfunction

  task automatic wait_hi(input int w, input int lim, input string nm);
    int n;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (pick(w) !== 1'b1 && n < lim);
    chk(nm, 32'h1, {31'h0, pick(w)});
  endtask

  task automatic quiet(input string nm);
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(negedge clk_in);
      seen = seen | (sen === 1'b1);
    end
    chk(nm, 32'h0, {31'h0, seen});
  endtask

  task automatic poll_busy();
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, `RTCS_IDX_CFG, 32'h0, q, e);
      n++;
    end while (q[3] !== 1'b0 && n < 20);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd(`RTCS_IDX_ALM_MIN, 32'h0, "alarm minute reset");
    rd(`RTCS_IDX_ALM_HR, 32'h0, "alarm hour reset");
    rd(`RTCS_IDX_CFG, 32'h0, "config reset");
    apb(1'b0, 14'h2883, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    wr(`RTCS_IDX_RES_HI, 32'hFF);
    rd(`RTCS_IDX_RES_HI, 32'h0, "read-only result");
    $display("test reset done");
  endtask

  task automatic t_targets();
    wr(`RTCS_IDX_ALM_MIN, 32'hFFFFFFFF);
    wr(`RTCS_IDX_ALM_HR, 32'hFFFFFFFF);
    rd(`RTCS_IDX_ALM_MIN, 32'h3F, "minute target width");
    rd(`RTCS_IDX_ALM_HR, 32'h1F, "hour target width");
    wake <= 1'b1;
    @(posedge clk_in);
    wake <= 1'b0;
    rd(`RTCS_IDX_ALM_MIN, 32'h0, "minute target wake");
    rd(`RTCS_IDX_ALM_HR, 32'h0, "hour target wake");
    $display("test targets done");
  endtask

  task automatic t_ticks();
    int c;
    int s;
    c = 0;
    s = 0;
    wait_hi(2, 1300, "first minute tick");
    do begin
      @(negedge clk_in);
      c++;
      if (sec_ev === 1'b1) s++;
      chk("shared interrupt", {31'h0, sec_ev | min_ev | alm_ev}, {31'h0, int6});
    end while (min_ev !== 1'b1 && c < 1300);
    chk("minute period", 32'd1200, c);
    chk("seconds per minute", 32'd60, s);
    $display("test ticks done");
  endtask

  task automatic t_alarm();
    logic [31:0] t;
    logic e;
    logic [5:0] m;
    logic [4:0] h;
    apb(1'b0, `RTCS_IDX_TIME, 32'h0, t, e);
    m = (t[13:8] == 6'd59) ? 6'd0 : t[13:8] + 6'd1;
    h = (t[13:8] != 6'd59) ? t[20:16] : (t[20:16] == 5'd23) ? 5'd0 : t[20:16] + 5'd1;
    wr(`RTCS_IDX_ALM_MIN, {26'h0, m});
    wr(`RTCS_IDX_ALM_HR, {27'h0, h});
    wait_hi(3, 1300, "alarm event");
    chk("alarm on minute tick", 32'h1, {31'h0, min_ev});
    chk("alarm interrupt", 32'h1, {31'h0, int6});
    apb(1'b0, `RTCS_IDX_TIME, 32'h0, t, e);
    chk("alarm time", {19'h0, h, 2'b00, m}, {19'h0, t[20:8]});
    $display("test alarm done");
  endtask

  task automatic t_manual();
    logic [10:0] cd;
    for (int i = 0; i < 3; i++) begin
      cd = (i == 0) ? 11'h400 : (i == 1) ? 11'h3FF : 11'h0A5;
      mode <= (i == 1) ? PM_BROWNOUT : PM_MISSION;
      code <= cd;
      wr(`RTCS_IDX_START, 32'h40);
      wait_hi(0, 40, "manual run starts");
      wait_hi(1, 40, "manual run ends");
      rd(`RTCS_IDX_RES_HI, {24'h0, cd[10:3]}, "result high");
      rd(`RTCS_IDX_RES_LO, {24'h0, cd[2:0], 5'h0}, "result low");
    end
    mode <= PM_SLEEP;
    wr(`RTCS_IDX_START, 32'h40);
    quiet("start in sleep");
    // Inputs move only just after a rising edge
    @(posedge clk_in);
    mode <= PM_DISPLAY_ONLY;
    wr(`RTCS_IDX_START, 32'h40);
    quiet("start in display");
    $display("test manual done");
  endtask

  task automatic t_config();
    logic [31:0] q;
    logic e;
    int c;
    int r;
    logic prev;
    @(posedge clk_in);
    mode <= PM_MISSION;
    wr(`RTCS_IDX_CFG, 32'hC1);
    apb(1'b0, `RTCS_IDX_CFG, 32'h0, q, e);
    chk("busy while commit", 32'h1, {31'h0, q[3]});
    wr(`RTCS_IDX_CFG, 32'h07);
    poll_busy();
    rd(`RTCS_IDX_CFG, 32'hC1, "write while busy ignored");
    chk("supply main", 32'h1, {31'h0, supply});
    chk("battery select", 32'h1, {31'h0, bsel});
    wr(`RTCS_IDX_START, 32'h40);
    quiet("start with period set");
    @(posedge clk_in);
    mode <= PM_SLEEP;
    repeat (2) @(posedge clk_in);
    chk("supply in sleep", 32'h0, {31'h0, supply});
    c = 0;
    do begin
      @(negedge clk_in);
      c++;
    end while (sen !== 1'b1 && c < 400);
    chk("periodic interval", 32'h1, {31'h0, c >= 260 && c <= 345});
    wait_hi(1, 40, "periodic run ends");
    @(posedge clk_in);
    mode <= PM_DISPLAY_ONLY;
    wr(`RTCS_IDX_CFG, 32'h07);
    poll_busy();
    r = 0;
    prev = sen;
    repeat (60) begin
      @(negedge clk_in);
      if (sen === 1'b1 && prev !== 1'b1) r++;
      prev = sen;
    end
    chk("continuous runs", 32'h1, {31'h0, r >= 3});
    $display("test config done");
  endtask

  task automatic wrap_up();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_targets();
    t_ticks();
    t_alarm();
    t_manual();
    t_config();
    wrap_up();
  end
endmodule
